// [lpds_dimcurve.v]
// conduction phase to output current level
`timescale 1ns/100ps
`default_nettype none
`include "lpds_map.vh"
module lpds_dimcurve (
   input  wire       phase_i,
   input  wire [7:0] cond_i,
   input  wire       limited_i,
   input  wire       dimmer_i,
   output reg  [7:0] level_o
);
   reg [7:0] linlog;

   // linear tail below the knee keeps low end smooth
   always @* begin
      if (cond_i < `LPDS_CURVE_KNEE)
         linlog = `LPDS_CURVE_LOW + {2'h0, cond_i[7:2]};
      else
         linlog = cond_i;
      if (!phase_i)
         level_o = 8'h00;
      else if (limited_i && !dimmer_i)
         level_o = `LPDS_CURVE_FULL;
      else if (limited_i && linlog > `LPDS_CURVE_LIMIT)
         level_o = `LPDS_CURVE_LIMIT;
      else
         level_o = linlog;
   end
endmodule // lpds_dimcurve
`default_nettype wire

// [lpds_map.vh]
// constants of the supervisor
`ifndef LPDS_MAP_VH
`define LPDS_MAP_VH
`define LPDS_CLK_MHZ 100
`define LPDS_IDLE_GAP_NS 1800
`define LPDS_IDLE_GAP_CYC (((`LPDS_IDLE_GAP_NS)*(`LPDS_CLK_MHZ)+999)/1000)
`define LPDS_UNDERVOLTAGE_LOCKOUT_BACKOFF_MS 14'h03E8
`define LPDS_LONG_BACKOFF_MS 14'h2328
`define LPDS_DET_HALF_MAX 5'h10
`define LPDS_DET_CONFIRM 3'h4
`define LPDS_STRETCH_STEP 16'h0014
`define LPDS_BLEED_WIN 8'h08
`define LPDS_CURVE_LOW 8'h10
`define LPDS_CURVE_KNEE 8'h40
`define LPDS_CURVE_LIMIT 8'hC0
`define LPDS_CURVE_FULL 8'hFF
`define LPDS_ADDR_CTRL 8'h00
`define LPDS_ADDR_STATUS 8'h04
`define LPDS_ADDR_LEVEL 8'h08
`define LPDS_CTRL_RESET 2'h3
`define LPDS_CTRL_RUN 0
`define LPDS_CTRL_BLEED 1
`define LPDS_DIM_NONE 2'h0
`define LPDS_DIM_LEAD 2'h1
`define LPDS_DIM_TRAIL 2'h2
`define LPDS_RESP_OKAY 2'h0
`define LPDS_RESP_SLVERR 2'h2
`endif

// [lpds_plant.sv]
// power switch, current sense and drain ringing model
`timescale 1ns/100ps
`default_nettype none
module lpds_plant (
   input  wire logic       mclk_i,
   input  wire logic       switch_drive_i,
   input  wire logic [7:0] peak_cyc_i,
   input  wire logic       short_i,
   output var  logic       peak_o = 1'b0,
   output var  logic       demag_o = 1'b0,
   output var  logic       valley_o = 1'b0
);
   logic [9:0] cnt = 10'h000;
   logic       sw_q = 1'b0;
   // cycles since last switch edge, outputs registered
   always @(posedge mclk_i) begin
      sw_q     <= switch_drive_i;
      cnt      <= (switch_drive_i !== sw_q) ? 10'h000 : cnt + {9'h000, ~&cnt};
      // a shorted output never demagnetises nor rings
      peak_o   <= switch_drive_i && cnt >= {2'h0, peak_cyc_i};
      demag_o  <= !switch_drive_i && !short_i && cnt == 10'h014;
      valley_o <= !switch_drive_i && !short_i && cnt > 10'h014
                  && cnt[2:0] == 3'h0;
   end
endmodule // lpds_plant
`default_nettype wire

// [lpds_tb.sv]
// self-checking bench for the supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, mute = 1'b0, short_q = 1'b0;
   logic supply_start_level_i = 1'b1, supply_stop_level_i = 1'b0;
   logic supply_overvoltage_level_i = 1'b0, cycle_request_i = 1'b1;
   logic overtemp_activate_level_i = 1'b0, overtemp_release_level_i = 1'b1;
   logic mains_zero_cross_i = 1'b0, mains_high_i = 1'b0;
   logic mains_step_rise_i = 1'b0, mains_step_fall_i = 1'b0;
   logic bleed_sense_low_i = 1'b0, dim_mode_strap_i = 1'b1;
   logic current_sense_peak_i, valley_i, demag_end_i, switch_drive_o;
   logic bleeder_strong_o, bleeder_weak_o, hv_source_en_o, s_axi_bvalid_o;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
   logic s_axi_bready_i = 1'b0, s_axi_rready_i = 1'b0, s_axi_awready_o;
   logic s_axi_wready_o, s_axi_arready_o, s_axi_rvalid_o;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, bq[$];
   logic [3:0]  s_axi_wstrb_i = 4'hF;
   logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, led_level_o;
   logic [7:0]  peak_cyc = 8'h40, ph = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
   logic [65:0] rq[$];
   int          err_count = 0, n_checks = 0, seed;
   lpds_top #(.TICK_CYC(2), .TON_MAX_CYC(200), .TOFF_MAX_CYC(300),
      .MAINS_LOSS_MS(1000)) lpds_top_i (.*);
   lpds_plant lpds_plant_i (.mclk_i, .switch_drive_i(switch_drive_o),
      .peak_cyc_i(peak_cyc), .short_i(short_q), .peak_o(current_sense_peak_i),
      .demag_o(demag_end_i), .valley_o(valley_i));
   initial forever #5 mclk_i = ~mclk_i;
   // 200-cycle half mains period, no dimmer edges
   always @(posedge mclk_i) begin
      ph                 <= (ph == 8'hC7) ? 8'h00 : ph + 8'h01;
      mains_zero_cross_i <= (ph == 8'h00) && !mute;
      mains_high_i       <= (ph > 8'h14) && !mute;
      bleed_sense_low_i  <= 1'($urandom);
   end
   task conclude(input int e);
      err_count += e;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task cmp_r(input [65:0] n);
      n_checks++;
      if ({s_axi_rresp_o, s_axi_rdata_o & n[63:32]} !== {n[65:64], n[31:0]}) begin
         err_count++;
         $display("BAD %0t %h %h", $time, {s_axi_rresp_o, s_axi_rdata_o}, n);
      end
   endtask
   task cmp_b(input [1:0] e);
      n_checks++;
      if (s_axi_bresp_o !== e) begin
         err_count++;
         $display("BAD %0t %h %h", $time, s_axi_bresp_o, e);
      end
   endtask
   // responses sampled where settled, half a cycle before the edge
   always @(negedge mclk_i) begin
      if (s_axi_bvalid_o && s_axi_bready_i) cmp_b(bq.pop_front());
      if (s_axi_rvalid_o && s_axi_rready_i) cmp_r(rq.pop_front());
   end
   // one bus transfer; d is write data or read mask
   task xfer(input w, input [7:0] a, input [31:0] d, e, input [1:0] r);
      logic [3:0] t;
      if (w) bq.push_back(r);
      else rq.push_back({r, d, e & d});
      s_axi_awaddr_i <= a;
      s_axi_araddr_i <= a;
      s_axi_wdata_i <= d;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {3{w}};
      {s_axi_arvalid_i, s_axi_rready_i} <= {2{!w}};
      for (int k = 0; k < 64; k++) begin
         @(negedge mclk_i);
         t = {s_axi_awready_o, s_axi_wready_o, s_axi_arready_o,
              s_axi_bvalid_o | s_axi_rvalid_o};
         @(posedge mclk_i);
         if (t[3]) s_axi_awvalid_i <= 1'b0;
         if (t[2]) s_axi_wvalid_i <= 1'b0;
         if (t[1]) s_axi_arvalid_i <= 1'b0;
         if (t[0]) begin
            {s_axi_bready_i, s_axi_rready_i} <= 2'b00;
            @(posedge mclk_i);
            return;
         end
      end
      conclude(1);
   endtask
   task st(input [31:0] m, e);
      xfer(1'b0, 8'h04, m, e, 2'h0);
   endtask
   task wait_lvl(input [7:0] v);
      int k;
      for (k = 0; k < 30000 && led_level_o !== v; k++) @(negedge mclk_i);
      @(posedge mclk_i);
      if (k == 30000) conclude(1);
   endtask
   initial begin
      seed = $urandom(88);
      peak_cyc = 8'h28 + 8'($urandom % 100);
      repeat (2) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      xfer(1'b0, 8'h00, 32'hFFFFFFFF, 32'h3, 2'h0);
      xfer(1'b0, 8'h0C, 32'h0, 32'h0, 2'h2);
      xfer(1'b1, 8'h0C, $urandom, 32'h0, 2'h2);
      wait_lvl(8'hFF);
      st(32'hE7, 32'h22);
      {overtemp_activate_level_i, overtemp_release_level_i} <= 2'b10;
      repeat (4) @(posedge mclk_i);
      st(32'h7, 32'h3);
      {overtemp_activate_level_i, overtemp_release_level_i} <= 2'b01;
      peak_cyc <= 8'hFF;
      wait_lvl(8'hFF);
      {supply_stop_level_i, supply_start_level_i} <= 2'b10;
      repeat (4) @(posedge mclk_i);
      {supply_stop_level_i, supply_start_level_i} <= 2'b01;
      repeat (1500) @(posedge mclk_i);
      st(32'h7, 32'h0);
      wait_lvl(8'hFF);
      mute <= 1'b1;
      repeat (2100) @(posedge mclk_i);
      st(32'h7, 32'h3);
      mute <= 1'b0;
      wait_lvl(8'hFF);
      short_q <= 1'b1;
      wait_lvl(8'h00);
      short_q <= 1'b0;
      repeat (15000) @(posedge mclk_i);
      st(32'h7, 32'h0);
      wait_lvl(8'hFF);
      supply_overvoltage_level_i <= 1'b1;
      @(posedge mclk_i);
      supply_overvoltage_level_i <= 1'b0;
      repeat (50) @(posedge mclk_i);
      st(32'h7, 32'h4);
      conclude(0);
   end
endmodule // testbench
`default_nettype wire

// [lpds_timer.v]
// loadable down counter for back-off timers
`timescale 1ns/100ps
`default_nettype none
module lpds_timer #(
   parameter W = 16
) (
   input  wire         mclk_i,
   input  wire         rst_n_i,
   input  wire         load_i,
   input  wire [W-1:0] val_i,
   input  wire         en_i,
   output wire         zero_o
);
   reg [W-1:0] cnt_reg;

   // load wins over counting; holds at zero
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= {W{1'b0}};
      end else if (load_i) begin
         cnt_reg <= val_i;
      end else if (en_i && (cnt_reg != {W{1'b0}})) begin
         cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign zero_o = (cnt_reg == {W{1'b0}});
endmodule // lpds_timer
`default_nettype wire

// [lpds_top.v]
// supervisor top with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "lpds_map.vh"
// Notes on behaviour
// RULE1: idle gap under 1.8 us stretches the period.
// RULE2: tell leading, trailing or no dimmer; ignore pulses.
// RULE3: strong bleed around dimmer edge.
// RULE4: weak bleed loop holds total current.
// RULE5: strap at start-up picks dim curve.
// RULE6: limited curve: full with no dimmer.
// RULE7: overvoltage latches; others restart.
// RULE8: stop level halts, HV on; 1 s back-off.
// RULE9: peak ends on-time after blanking.
// RULE10: on-time capped at maximum.
// RULE11: off-time expiry starts short timer.
// RULE12: short timeout: standby, 9 s back-off.
// RULE13: output-open overvoltage: no restart.
// RULE14: overtemperature stops until release.
// RULE15: mains loss stops until crossings return.
// RULE16: peak ignored during blanking.
// RULE17: detection capped at 16 half-cycles, 9 s.
// RULE18: cycle starts at next valley.
// RULE19: inputs synchronous; limits parameters.
// RULE20: prescaled back-off; restart needs start level.
module lpds_top #(
   parameter TICK_CYC      = 100000,
   parameter LEB_CYC       = 30,
   parameter TON_MAX_CYC   = 1500,
   parameter TOFF_MAX_CYC  = 4800,
   parameter SHORT_DET_MS  = 50,
   parameter MAINS_LOSS_MS = 20,
   parameter PHASE_DIV_CYC = 3906
) (
   input  wire        mclk_i,
   input  wire        rst_n_i,
   input  wire        supply_start_level_i,
   input  wire        supply_stop_level_i,
   input  wire        supply_overvoltage_level_i,
   input  wire        overtemp_activate_level_i,
   input  wire        overtemp_release_level_i,
   input  wire        mains_zero_cross_i,
   input  wire        mains_high_i,
   input  wire        mains_step_rise_i,
   input  wire        mains_step_fall_i,
   input  wire        current_sense_peak_i,
   input  wire        valley_i,
   input  wire        demag_end_i,
   input  wire        cycle_request_i,
   input  wire        bleed_sense_low_i,
   input  wire        dim_mode_strap_i,
   output reg         switch_drive_o,
   output reg         bleeder_strong_o,
   output reg         bleeder_weak_o,
   output wire        hv_source_en_o,
   output reg  [7:0]  led_level_o,
   input  wire [7:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   output reg  [1:0]  s_axi_bresp_o,
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [7:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i
);
   localparam ST_WAIT  = 3'h0;
   localparam ST_DET   = 3'h1;
   localparam ST_RUN   = 3'h2;
   localparam ST_HALT  = 3'h3;
   localparam ST_LATCH = 3'h4;
   localparam SW_RING  = 2'h0;
   localparam SW_ON    = 2'h1;
   localparam SW_SEC   = 2'h2;
   localparam [15:0] LEB_C  = LEB_CYC;
   localparam [15:0] TON_C  = TON_MAX_CYC - 1;
   localparam [15:0] TOFF_C = TOFF_MAX_CYC - 1;
   localparam [15:0] GAP_C  = `LPDS_IDLE_GAP_CYC;
   localparam [16:0] TICK_C = TICK_CYC - 1;
   localparam [11:0] PDIV_C = PHASE_DIV_CYC - 1;
   localparam [15:0] SDET_C = SHORT_DET_MS;
   localparam [15:0] MLOS_C = MAINS_LOSS_MS;

   reg  [2:0]  st_reg;
   reg  [2:0]  st_next;
   reg  [1:0]  sw_reg;
   reg  [1:0]  ctrl_reg;
   reg  [16:0] tick_cnt_reg;
   reg         tick_reg;
   reg         bo_sup_reg;
   reg  [13:0] bo_val;
   reg         bo_load;
   reg         otp_reg;
   reg         curve_reg;
   reg  [15:0] on_cnt_reg;
   reg  [15:0] off_cnt_reg;
   reg  [15:0] gap_cnt_reg;
   reg  [15:0] stretch_reg;
   reg         toff_hit_reg;
   reg         osp_run_reg;
   reg  [11:0] pdiv_reg;
   reg  [7:0]  phase_cnt_reg;
   reg         saw_edge_reg;
   reg         edge_rise_reg;
   reg  [7:0]  edge_pos_reg;
   reg  [7:0]  edge_last_reg;
   reg  [1:0]  cls_prev_reg;
   reg  [2:0]  agree_reg;
   reg  [4:0]  half_cnt_reg;
   reg         det_done_reg;
   reg  [1:0]  dim_type_reg;
   reg  [7:0]  cond_reg;
   reg         aw_hold_reg;
   reg         w_hold_reg;
   reg  [7:0]  aw_addr_reg;
   reg  [31:0] w_data_reg;
   reg  [3:0]  w_strb_reg;
   wire        bo_zero;
   wire        sdet_zero;
   wire        mloss_zero;
   wire        sw_en;
   wire        osp_trip;
   wire        mloss;
   wire        det_fail;
   wire        turn_on;
   wire        turn_off;
   wire [1:0]  cls_now;
   wire [7:0]  cond_now;
   wire [7:0]  level_now;
   wire        win_edge;
   wire        do_write;

   assign sw_en    = (st_reg == ST_DET) || (st_reg == ST_RUN);
   assign osp_trip = osp_run_reg && sdet_zero; // [RULE12]
   assign mloss    = mloss_zero && sw_en; // [RULE15]
   assign det_fail = (st_reg == ST_DET) && mains_zero_cross_i &&
                     (half_cnt_reg == `LPDS_DET_HALF_MAX - 5'h01); // [RULE17]
   assign hv_source_en_o = !sw_en; // [RULE8]

   // ms tick for all back-off timing, keeps timers narrow [RULE20]
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_cnt_reg <= 17'h00000;
         tick_reg     <= 1'b0;
      end else begin
         tick_reg     <= (tick_cnt_reg == TICK_C);
         tick_cnt_reg <= (tick_cnt_reg == TICK_C) ? 17'h00000
                                                  : tick_cnt_reg + 17'h00001;
      end
   end

   // protection state: latched overvoltage outranks everything [RULE7]
   always @* begin
      st_next = st_reg;
      bo_load = 1'b0;
      bo_val  = `LPDS_UNDERVOLTAGE_LOCKOUT_BACKOFF_MS;
      case (st_reg)
         ST_WAIT: begin
            if (supply_overvoltage_level_i)
               st_next = ST_LATCH;
            else if (bo_zero && supply_start_level_i) // [RULE20]
               st_next = ST_DET;
         end
         ST_DET, ST_RUN, ST_HALT: begin
            if (supply_overvoltage_level_i) begin
               st_next = ST_LATCH; // [RULE13]
            end else if (supply_stop_level_i) begin
               st_next = ST_WAIT; // [RULE8]
               bo_load = 1'b1;
            end else if (osp_trip || det_fail) begin
               st_next = ST_WAIT; // [RULE12] [RULE17]
               bo_load = 1'b1;
               bo_val  = `LPDS_LONG_BACKOFF_MS;
            end else if (st_reg == ST_HALT) begin
               if (!otp_reg && !mloss_zero && ctrl_reg[`LPDS_CTRL_RUN])
                  st_next = ST_DET; // [RULE14] [RULE15]
            end else if (otp_reg || mloss || !ctrl_reg[`LPDS_CTRL_RUN]) begin
               st_next = ST_HALT; // [RULE14] [RULE15]
            end else if (st_reg == ST_DET && det_done_reg) begin
               st_next = ST_RUN;
            end
         end
         ST_LATCH: st_next = ST_LATCH; // [RULE7] [RULE13]
         default:  st_next = ST_WAIT;
      endcase
   end

   // the 1 s back-off only counts while supply is at start level [RULE8]
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg     <= ST_WAIT;
         bo_sup_reg <= 1'b1;
         otp_reg    <= 1'b0;
         curve_reg  <= 1'b0;
      end else begin
         st_reg <= st_next;
         if (bo_load)
            bo_sup_reg <= (bo_val == `LPDS_UNDERVOLTAGE_LOCKOUT_BACKOFF_MS);
         if (overtemp_activate_level_i)
            otp_reg <= 1'b1; // [RULE14]
         else if (overtemp_release_level_i)
            otp_reg <= 1'b0;
         if (st_reg == ST_WAIT)
            curve_reg <= dim_mode_strap_i; // [RULE5]
      end
   end

   lpds_timer #(.W(14)) u_backoff (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .load_i  (bo_load),
      .val_i   (bo_val),
      .en_i    (tick_reg && (!bo_sup_reg || supply_start_level_i)),
      .zero_o  (bo_zero)
   ); // [RULE20]

   lpds_timer #(.W(16)) u_short (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .load_i  (!osp_run_reg),
      .val_i   (SDET_C),
      .en_i    (tick_reg),
      .zero_o  (sdet_zero)
   ); // [RULE11]

   lpds_timer #(.W(16)) u_mloss (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .load_i  (mains_zero_cross_i || st_reg == ST_WAIT),
      .val_i   (MLOS_C),
      .en_i    (tick_reg),
      .zero_o  (mloss_zero)
   ); // [RULE15]

   // blanking hides the turn-on spike from the peak comparator
   assign turn_off = !sw_en ||
                     // [RULE9] [RULE16]
                     (on_cnt_reg >= LEB_C && current_sense_peak_i) ||
                     (on_cnt_reg >= TON_C); // [RULE10]
   assign turn_on  = sw_en && cycle_request_i &&
                     (valley_i || toff_hit_reg) && // [RULE18]
                     (gap_cnt_reg >= stretch_reg); // [RULE1]

   // switching cycle: on, secondary stroke, ringing until valley
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sw_reg         <= SW_RING;
         switch_drive_o <= 1'b0;
         on_cnt_reg     <= 16'h0000;
         off_cnt_reg    <= 16'h0000;
         gap_cnt_reg    <= 16'h0000;
         stretch_reg    <= 16'h0000;
         toff_hit_reg   <= 1'b0;
         osp_run_reg    <= 1'b0;
      end else begin
         if (off_cnt_reg != 16'hFFFF)
            off_cnt_reg <= off_cnt_reg + 16'h0001;
         if (off_cnt_reg == TOFF_C && sw_reg != SW_ON) begin
            toff_hit_reg <= 1'b1;
            osp_run_reg  <= 1'b1; // [RULE11]
         end else if (sw_reg == SW_RING && valley_i && !toff_hit_reg) begin
            osp_run_reg  <= 1'b0; // [RULE11]
         end
         if (!sw_en)
            osp_run_reg <= 1'b0;
         case (sw_reg)
            SW_ON: begin
               on_cnt_reg <= on_cnt_reg + 16'h0001;
               if (turn_off) begin
                  switch_drive_o <= 1'b0;
                  off_cnt_reg    <= 16'h0000;
                  toff_hit_reg   <= 1'b0;
                  sw_reg         <= SW_SEC;
               end
            end
            SW_SEC: begin
               gap_cnt_reg <= 16'h0000;
               if (demag_end_i || toff_hit_reg)
                  sw_reg <= SW_RING;
            end
            SW_RING: begin
               if (gap_cnt_reg != 16'hFFFF)
                  gap_cnt_reg <= gap_cnt_reg + 16'h0001;
               if (turn_on) begin
                  switch_drive_o <= 1'b1;
                  on_cnt_reg     <= 16'h0000;
                  sw_reg         <= SW_ON;
                  // short idle gap means nearly continuous conduction
                  if (gap_cnt_reg < GAP_C) begin
                     if (stretch_reg < 16'hFF00)
                        stretch_reg <= stretch_reg + `LPDS_STRETCH_STEP; // [RULE1]
                  end else if (stretch_reg != 16'h0000) begin
                     stretch_reg <= stretch_reg - 16'h0001;
                  end
               end
            end
            default: sw_reg <= SW_RING;
         endcase
      end
   end

   // first steep edge per half-cycle only: smart dimmer pulses ignored
   assign cls_now  = !saw_edge_reg ? `LPDS_DIM_NONE :
                     edge_rise_reg ? `LPDS_DIM_LEAD : `LPDS_DIM_TRAIL; // [RULE2]
   assign cond_now = (cls_now == `LPDS_DIM_LEAD)  ? ~edge_pos_reg :
                     (cls_now == `LPDS_DIM_TRAIL) ? edge_pos_reg :
                     `LPDS_CURVE_FULL;

   // phase tracking and dimmer classification per half-cycle
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pdiv_reg      <= 12'h000;
         phase_cnt_reg <= 8'h00;
         saw_edge_reg  <= 1'b0;
         edge_rise_reg <= 1'b0;
         edge_pos_reg  <= 8'h00;
         edge_last_reg <= 8'h00;
         cls_prev_reg  <= `LPDS_DIM_NONE;
         agree_reg     <= 3'h0;
         half_cnt_reg  <= 5'h00;
         det_done_reg  <= 1'b0;
         dim_type_reg  <= `LPDS_DIM_NONE;
         cond_reg      <= `LPDS_CURVE_FULL;
      end else if (mains_zero_cross_i) begin
         pdiv_reg      <= 12'h000;
         phase_cnt_reg <= 8'h00;
         saw_edge_reg  <= 1'b0;
         edge_last_reg <= edge_pos_reg;
         cls_prev_reg  <= cls_now;
         agree_reg     <= (cls_now == cls_prev_reg && agree_reg != 3'h7)
                          ? agree_reg + 3'h1 : 3'h1;
         if (st_reg == ST_DET) begin
            half_cnt_reg <= half_cnt_reg + 5'h01; // [RULE17]
            if (cls_now == cls_prev_reg &&
                agree_reg >= `LPDS_DET_CONFIRM - 3'h1) begin
               det_done_reg <= 1'b1;
               dim_type_reg <= cls_now; // [RULE2]
            end
         end
         if (det_done_reg)
            cond_reg <= cond_now;
      end else begin
         if (pdiv_reg == PDIV_C) begin
            pdiv_reg <= 12'h000;
            if (phase_cnt_reg != 8'hFF)
               phase_cnt_reg <= phase_cnt_reg + 8'h01;
         end else begin
            pdiv_reg <= pdiv_reg + 12'h001;
         end
         if (!saw_edge_reg && (mains_step_rise_i || mains_step_fall_i)) begin
            saw_edge_reg  <= 1'b1;
            edge_rise_reg <= mains_step_rise_i;
            edge_pos_reg  <= phase_cnt_reg;
         end
         if (st_reg != ST_DET && st_reg != ST_RUN) begin
            half_cnt_reg <= 5'h00;
            det_done_reg <= 1'b0;
         end
      end
   end

   lpds_dimcurve u_curve (
      .phase_i   (st_reg == ST_RUN),
      .cond_i    (cond_reg),
      .limited_i (curve_reg),
      .dimmer_i  (dim_type_reg != `LPDS_DIM_NONE),
      .level_o   (level_now)
   ); // [RULE5] [RULE6]

   // window straddles last edge; near zero cross it loads the mains
   assign win_edge = (phase_cnt_reg + `LPDS_BLEED_WIN >= edge_last_reg) &&
                     (phase_cnt_reg <= edge_last_reg + `LPDS_BLEED_WIN);

   // registered bleeder commands and output level
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bleeder_strong_o <= 1'b0;
         bleeder_weak_o   <= 1'b0;
         led_level_o      <= 8'h00;
      end else begin
         led_level_o      <= level_now;
         bleeder_strong_o <= sw_en && ctrl_reg[`LPDS_CTRL_BLEED] &&
                             (win_edge || phase_cnt_reg < `LPDS_BLEED_WIN); // [RULE3]
         // bang-bang loop: bleed while total current is under target
         bleeder_weak_o   <= sw_en && ctrl_reg[`LPDS_CTRL_BLEED] &&
                             mains_high_i && bleed_sense_low_i &&
                             !win_edge; // [RULE4]
      end
   end

   // AXI4-Lite: address and data caught in either order, one at a time
   assign s_axi_awready_o = !aw_hold_reg && !s_axi_bvalid_o;
   assign s_axi_wready_o  = !w_hold_reg && !s_axi_bvalid_o;
   assign s_axi_arready_o = !s_axi_rvalid_o;
   assign do_write        = aw_hold_reg && w_hold_reg && !s_axi_bvalid_o;

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_hold_reg    <= 1'b0;
         w_hold_reg     <= 1'b0;
         aw_addr_reg    <= 8'h00;
         w_data_reg     <= 32'h00000000;
         w_strb_reg     <= 4'h0;
         ctrl_reg       <= `LPDS_CTRL_RESET;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= `LPDS_RESP_OKAY;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rresp_o  <= `LPDS_RESP_OKAY;
         s_axi_rdata_o  <= 32'h00000000;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i;
            w_strb_reg <= s_axi_wstrb_i;
         end
         if (do_write) begin
            aw_hold_reg    <= 1'b0;
            w_hold_reg     <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= `LPDS_RESP_OKAY;
            if (aw_addr_reg == `LPDS_ADDR_CTRL) begin
               if (w_strb_reg[0])
                  ctrl_reg <= w_data_reg[1:0];
            end else if (aw_addr_reg != `LPDS_ADDR_STATUS &&
                         aw_addr_reg != `LPDS_ADDR_LEVEL) begin
               s_axi_bresp_o <= `LPDS_RESP_SLVERR;
            end
         end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= `LPDS_RESP_OKAY;
            case (s_axi_araddr_i)
               `LPDS_ADDR_CTRL:   s_axi_rdata_o <= {30'h0, ctrl_reg};
               `LPDS_ADDR_STATUS: s_axi_rdata_o <= {23'h0, det_done_reg,
                  dim_type_reg, curve_reg, osp_run_reg, otp_reg, st_reg};
               `LPDS_ADDR_LEVEL:  s_axi_rdata_o <= {stretch_reg[7:0],
                  cond_reg, led_level_o, 8'h00};
               default: begin
                  s_axi_rdata_o <= 32'h00000000;
                  s_axi_rresp_o <= `LPDS_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end
endmodule // lpds_top
`default_nettype wire

// [lpds_top_properties.sv]
// assertions on the supervisor top-level ports
`timescale 1ns/100ps
`default_nettype none
module lpds_chk #(
   parameter LEB_CYC     = 30,
   parameter TON_MAX_CYC = 1500,
   parameter TOFF_MAX_CYC = 4800
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic switch_drive_o,
   input wire logic hv_source_en_o,
   input wire logic current_sense_peak_i,
   input wire logic valley_i,
   input wire logic supply_overvoltage_level_i,
   input wire logic supply_stop_level_i,
   input wire logic overtemp_activate_level_i
);
   logic [15:0] on_cnt;
   logic        ov_seen;
   logic [15:0] off_cnt;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // on-time length; overvoltage memory cleared by reset only
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         on_cnt  <= 16'h0000;
         ov_seen <= 1'b0;
         off_cnt <= 16'h0000;
      end else begin
         // off-time expiry may start a cycle without a valley
         off_cnt <= switch_drive_o ? 16'h0000 : off_cnt + {15'h0, ~&off_cnt};
         on_cnt  <= switch_drive_o ? on_cnt + 16'h0001 : 16'h0000;
         ov_seen <= ov_seen | supply_overvoltage_level_i;
      end
   end
   sequence s_off;
      ##[1:3] !switch_drive_o;
   endsequence
   sequence s_blank;
      (switch_drive_o || hv_source_en_o) [*8];
   endsequence
   a_blank_holds: assert property ($rose(switch_drive_o) |-> s_blank)
      else $error("on-time ended inside blanking");
   a_ton_cap: assert property (on_cnt <= TON_MAX_CYC + 1)
      else $error("on-time above limit");
   a_peak_ends: assert property (switch_drive_o && current_sense_peak_i
      && on_cnt > LEB_CYC + 2 |-> ##[1:2] !switch_drive_o)
      else $error("peak did not end on-time");
   a_valley_on: assert property ($rose(switch_drive_o) |->
      $past(valley_i) || off_cnt >= TOFF_MAX_CYC - 1)
      else $error("turn-on without valley");
   a_ovp_stop: assert property (supply_overvoltage_level_i |-> s_off)
      else $error("switching on overvoltage");
   a_ovp_latch: assert property (ov_seen |-> ##3 !switch_drive_o)
      else $error("switching after overvoltage");
   a_undervoltage_lockout_halt: assert property (supply_stop_level_i
      |-> ##[1:3] (hv_source_en_o && !switch_drive_o))
      else $error("no halt below stop level");
   a_otp_stop: assert property (overtemp_activate_level_i |-> s_off)
      else $error("switching when hot");
endmodule // lpds_chk
bind lpds_top lpds_chk #(.LEB_CYC(LEB_CYC), .TON_MAX_CYC(TON_MAX_CYC),
   .TOFF_MAX_CYC(TOFF_MAX_CYC))
   lpds_chk_i (.*);
`default_nettype wire
